// >>> rtl/wwd_pkg.sv
package wwd_pkg;
  // time base: 20 MHz clock, one tick per microsecond
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = (CLK_FREQ_HZ / 1000000) * TICK_US;
  localparam int unsigned TICK_W = 5;
  // window timing in ticks (microseconds)
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] RST_DELAY_US = 16'h00C8;
  localparam logic [CNT_W-1:0] LOW_LIMIT_BASE_US = 16'h0064;
  localparam logic [CNT_W-1:0] UPPER_LIMIT_BASE_US = 16'h03E8;
  localparam logic [CNT_W-1:0] CAP_SCALE_STEP = 16'h0002;
  // window-select code that disables the watchdog
  localparam logic [1:0] SEL_DISABLE = 2'h2;

  typedef struct packed {
    logic [CNT_W-1:0] lower_window_limit;
    logic [CNT_W-1:0] upper_window_limit;
    logic disabled;
  } wwd_window_t;
endpackage : wwd_pkg

// >>> rtl/wwd_tick.sv
`timescale 1ns/10ps
module wwd_tick #(
  parameter int unsigned DIV = wwd_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  output logic tick
);
  logic [wwd_pkg::TICK_W-1:0] cnt_r;
  wire last = (cnt_r == wwd_pkg::TICK_W'(DIV - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt_r <= '0;
    else if (last) cnt_r <= '0;
    else cnt_r <= cnt_r + 1'b1;
  end
  assign tick = last;
endmodule : wwd_tick

// >>> rtl/window_watchdog_core.sv
`timescale 1ns/10ps
// How it works
// - kicks ignored at power-up until reset delay elapses.
// - kicks ignored while fault output is low.
// - kicks ignored while watchdog is disabled.
// - timeout drives fault output low.
// - fault stays low for the reset delay to within one tick, then released high.
// - disabled watchdog holds fault output high regardless of kicks.
// - disabling window-select code turns the watchdog off.
// - window selects and capacitor setting choose window, timeout or disable.
module window_watchdog_core #(
  parameter logic [wwd_pkg::CNT_W-1:0] RST_DELAY = wwd_pkg::RST_DELAY_US
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic kick_input,
  input wire logic window_select_0,
  input wire logic window_select_1,
  input wire logic [1:0] timeout_cap_setting,
  output logic fault_output_n
);
  typedef enum logic [1:0] {ST_POWERUP, ST_WATCH, ST_FAULT, ST_OFF} wwd_state_t;
  wwd_state_t state_r, state_nxt;
  logic [wwd_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic kick_d_r;
  logic fault_n_r;
  logic tick;

  wwd_tick u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick)
  );

  function automatic wwd_pkg::wwd_window_t decode_window(input logic [1:0] sel,
                                                          input logic [1:0] cap);
    wwd_pkg::wwd_window_t w;
    logic [wwd_pkg::CNT_W-1:0] scale;
    scale = wwd_pkg::CNT_W'(cap) * wwd_pkg::CAP_SCALE_STEP + 16'h0001;
    w.disabled = (sel == wwd_pkg::SEL_DISABLE);
    w.upper_window_limit = wwd_pkg::CNT_W'(wwd_pkg::UPPER_LIMIT_BASE_US * scale);
    w.lower_window_limit = wwd_pkg::CNT_W'((wwd_pkg::LOW_LIMIT_BASE_US << sel) * scale);
    return w;
  endfunction : decode_window

  wire [1:0] sel = {window_select_1, window_select_0};
  wwd_pkg::wwd_window_t win;
  assign win = decode_window(sel, timeout_cap_setting);

  wire kick_fall = kick_d_r & ~kick_input;
  wire too_early = cnt_r < win.lower_window_limit;
  wire timed_out = tick && (cnt_r >= win.upper_window_limit - 16'h0001);
  wire delay_done = tick && (cnt_r >= RST_DELAY - 16'h0001);
  wire [wwd_pkg::CNT_W-1:0] cnt_inc = tick ? cnt_r + 16'h0001 : cnt_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_inc;
    case (state_r)
      ST_POWERUP: begin
        // kicks are not looked at here
        if (delay_done) begin
          state_nxt = win.disabled ? ST_OFF : ST_WATCH;
          cnt_nxt = '0;
        end
      end
      ST_WATCH: begin
        if (win.disabled) begin
          state_nxt = ST_OFF;
          cnt_nxt = '0;
        end else if (kick_fall && too_early) begin
          state_nxt = ST_FAULT;
          cnt_nxt = '0;
        end else if (kick_fall) begin
          cnt_nxt = '0;
        end else if (timed_out) begin
          state_nxt = ST_FAULT;
          cnt_nxt = '0;
        end
      end
      ST_FAULT: begin
        // kicks ignored while asserted
        if (delay_done) begin
          state_nxt = win.disabled ? ST_OFF : ST_WATCH;
          cnt_nxt = '0;
        end
      end
      ST_OFF: begin
        cnt_nxt = '0;
        if (!win.disabled) state_nxt = ST_WATCH;
      end
      default: begin
        state_nxt = ST_POWERUP;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_POWERUP;
      cnt_r <= '0;
      kick_d_r <= 1'b0;
      fault_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      kick_d_r <= kick_input;
      fault_n_r <= (state_nxt != ST_FAULT);
    end
  end

  assign fault_output_n = fault_n_r;

  // fault low time in clocks: the first tick after entry lands 1..TICK_CYCLES clocks late
  localparam int unsigned LOW_MIN = (32'(RST_DELAY) - 1) * wwd_pkg::TICK_CYCLES + 1;
  localparam int unsigned LOW_MAX = 32'(RST_DELAY) * wwd_pkg::TICK_CYCLES;

  // low-time meter; saturates so a stuck fault cannot wrap it into the legal range
  logic [wwd_pkg::CNT_W+wwd_pkg::TICK_W-1:0] low_len_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) low_len_r <= '0;
    else if (fault_output_n) low_len_r <= '0;
    else if (!(&low_len_r)) low_len_r <= low_len_r + 1'b1;
  end

  AST_OFF_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_OFF |-> fault_output_n) else $error("fault low while disabled");
  AST_TIMEOUT_FAULT: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !win.disabled && !kick_fall && timed_out |=> !fault_output_n)
    else $error("timeout did not assert fault");
  AST_EARLY_FAULT: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !win.disabled && kick_fall && too_early |=> state_r == ST_FAULT)
    else $error("early kick not faulted");
  AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(fault_output_n) |-> !fault_output_n [*8]) else $error("fault pulse too short");
  AST_FAULT_KICK_IGN: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FAULT && !delay_done |=> state_r == ST_FAULT && cnt_r == $past(cnt_inc))
    else $error("kick disturbed fault");
  AST_POWERUP_IGN: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_POWERUP && !delay_done |=> state_r == ST_POWERUP && fault_output_n)
    else $error("kick seen during power-up");
  AST_DISABLE_ENTER: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && win.disabled |=> state_r == ST_OFF) else $error("disable ignored");
  AST_OFF_KICK_IGN: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_OFF |=> cnt_r == '0) else $error("kick counted while disabled");
  AST_RESTART: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !win.disabled && kick_fall && !too_early |=> cnt_r == '0)
    else $error("good kick did not restart");

  // pulse length is checked in clocks, so a broken tick or delay compare shows up here
  AST_FAULT_LEN: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(fault_output_n) |-> low_len_r >= LOW_MIN && low_len_r <= LOW_MAX)
    else $error("fault pulse length wrong");

  AST_POWERUP_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_POWERUP |-> fault_output_n)
    else $error("fault low during power-up");

  AST_PWR_EXIT: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_POWERUP && delay_done && !win.disabled |=> state_r == ST_WATCH && cnt_r == '0)
    else $error("power-up did not end in watch");

  AST_PWR_TO_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_POWERUP && delay_done && win.disabled |=> state_r == ST_OFF)
    else $error("power-up ignored disable");

  AST_FAULT_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FAULT |-> !fault_output_n)
    else $error("fault state with output high");

  AST_WATCH_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH |-> fault_output_n)
    else $error("fault low while watching");

  AST_EARLY_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !win.disabled && kick_fall && too_early |=> !fault_output_n)
    else $error("early kick left output high");

  AST_LATE_OK: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !win.disabled && kick_fall && !too_early |=> fault_output_n)
    else $error("in-window kick raised fault");

  AST_FAULT_CNT_RUN: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FAULT && tick && !delay_done |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("fault delay count stalled");

  AST_RELEASE_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FAULT && delay_done |=> fault_output_n)
    else $error("fault not released after delay");

  AST_RELEASE_RESTART: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_FAULT && delay_done |=> cnt_r == '0 && state_r != ST_FAULT)
    else $error("release did not restart period");

  AST_OFF_STAY: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_OFF && win.disabled |=> state_r == ST_OFF && fault_output_n)
    else $error("left disabled state while disabled");

  AST_OFF_LEAVE: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_OFF && !win.disabled |=> state_r == ST_WATCH && cnt_r == '0)
    else $error("enable did not start a fresh period");

  // the window counter counts up only on the time base; a falling kick clears it without a tick
  AST_CNT_STILL: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && !tick && !kick_fall && !win.disabled |=> cnt_r == $past(cnt_r))
    else $error("window count moved without tick");

  AST_CNT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    state_r == ST_WATCH && tick && !kick_fall && !timed_out && !win.disabled
    |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("window count missed a tick");

  AST_TICK_GAP: assert property (@(posedge clock) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("time base ticks too close");
endmodule : window_watchdog_core

// >>> bench/wwd_kicker.sv
`timescale 1ns/10ps
module wwd_kicker (
  input wire logic clock,
  input wire logic fire,
  output logic kick_input
);
  // high for one cycle, then low: the falling edge is the kick
  initial kick_input = 1'b0;
  always @(posedge clock) begin
    kick_input <= #1 fire;
  end
endmodule : wwd_kicker

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [15:0] RD = 16'h000A;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fire = 1'b0;
  logic sel0 = 1'b0;
  logic sel1 = 1'b0;
  logic [1:0] cap = 2'h0;
  logic kick_input;
  logic fault_output_n;
  int err_count = 0;
  int checks_done = 0;
  always #25 clock = ~clock;
  wwd_kicker i_kick (.clock(clock), .fire(fire), .kick_input(kick_input));
  window_watchdog_core #(.RST_DELAY(RD)) i_dut (.clock(clock), .rst_n(rst_n),
    .kick_input(kick_input), .window_select_0(sel0), .window_select_1(sel1),
    .timeout_cap_setting(cap), .fault_output_n(fault_output_n));
  task automatic idle(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  task automatic kick();
    fire = 1'b1;
    idle(1);
    fire = 1'b0;
  endtask : kick
  task automatic hold_high(string what, int n);
    repeat (n) begin
      idle(1);
      checks_done++;
      if (fault_output_n !== 1'b1) begin
        err_count++;
        $display("[FAIL] %s expected 1 seen %b", what, fault_output_n);
      end
    end
  endtask : hold_high
  // counts cycles until the output reaches lvl; a bound that runs out fails
  task automatic wait_lvl(string what, logic lvl, int lo, int hi);
    int n;
    n = 0;
    while (fault_output_n !== lvl && n <= hi) begin
      idle(1);
      n++;
    end
    checks_done++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
    if (n > hi) summarize();
  endtask : wait_lvl
  task automatic t_early();
    kick();
    hold_high("powerup", 300);
    kick();
    wait_lvl("early", 1'b0, 1, 3);
    kick();
    wait_lvl("fault_len", 1'b1, 175, 215);
    $display("test early done");
  endtask : t_early
  task automatic t_restart();
    idle(2500);
    kick();
    hold_high("in_window", 500);
    kick();
    wait_lvl("restart", 1'b0, 1, 3);
    cap = 2'h1;
    wait_lvl("fault_len2", 1'b1, 175, 215);
    idle(4000);
    kick();
    wait_lvl("cap_scale", 1'b0, 1, 3);
    wait_lvl("fault_len3", 1'b1, 175, 215);
    cap = 2'h0;
    $display("test restart done");
  endtask : t_restart
  task automatic t_sel();
    sel0 = 1'b1;
    idle(3000);
    kick();
    wait_lvl("sel_early", 1'b0, 1, 3);
    wait_lvl("fault_len5", 1'b1, 175, 215);
    idle(4500);
    kick();
    hold_high("sel_in_window", 100);
    sel0 = 1'b0;
    $display("test sel done");
  endtask : t_sel
  task automatic t_disable();
    sel1 = 1'b1;
    repeat (4) begin
      kick();
      hold_high("disabled", 100);
    end
    sel1 = 1'b0;
    $display("test disable done");
  endtask : t_disable
  task automatic t_timeout();
    wait_lvl("timeout", 1'b0, 19950, 20050);
    wait_lvl("fault_len4", 1'b1, 175, 215);
    $display("test timeout done");
  endtask : t_timeout
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    idle(20);
    rst_n = 1'b1;
    t_early();
    t_restart();
    t_sel();
    t_disable();
    t_timeout();
    summarize();
  end
endmodule : tb_top
